// ---- verilog/rssp_consts.svh ----
`ifndef RSSP_CONSTS_SVH
`define RSSP_CONSTS_SVH
// Overview of operation
// - At reset release the bus-mode strap is caught: high selects EEPROM master, low SMBus slave.
// - After reset with status output enabled, the bus-mode pin shows upstream suspend, high when suspended.
// - At reset release the power strap is caught: low enables power switching.
// - The caught power strap level also initialises the charge-mode limit bit.
// - Automatic charging with limit bit 0 allows every divider charging profile.
// - Automatic charging with limit bit 1 allows only the highest-current profile.
// - In SMBus mode slave address bit 1 comes from the caught power strap level.
// - After reset with status output enabled, the power pin is high while connected to a fast port.
// - At reset release the polarity strap is caught: 0 makes power outputs active low, 1 active high.
// - With full power management the four per-port power outputs control downstream power.
// - An auto-charge strap caught low enables automatic mode on charge-enabled ports while unconnected.
// - In SMBus mode the serial pins act as slave to a host, otherwise they serve an EEPROM.
// - In SMBus mode slave address bit 2 comes from the caught ganged-mode strap.
`define RSSP_NPORTS      4
`define RSSP_FILL_DONE   2'h3
`define RSSP_PROFILE_ALL 2'h0
`define RSSP_PROFILE_MAX 2'h1
`define RSSP_PROFILE_OFF 2'h2
`endif

// ---- verilog/rssp_pkg.sv ----
package rssp_pkg;
  typedef struct packed {
    logic bus_mode_strap;
    logic power_mgmt_strap_n;
    logic power_ctrl_polarity_strap;
    logic auto_charge_strap_n;
    logic slave_addr_bit2_strap;
  } rssp_straps_t;
  typedef enum logic [1:0] {
    RSSP_ST_RESET   = 2'h1,
    RSSP_ST_RUN     = 2'h2
  } rssp_state_t;
endpackage

// ---- verilog/rssp_top.sv ----
`include "rssp_consts.svh"
module rssp_top
  import rssp_pkg::*;
(
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  // dual-purpose pins, seen through pad input buffers
  input  wire logic                       bus_mode_pin_i,
  output logic                            bus_mode_pin_o,
  output logic                            bus_mode_pin_oe,
  input  wire logic                       power_mgmt_pin_i,
  output logic                            power_mgmt_pin_o,
  output logic                            power_mgmt_pin_oe,
  input  wire logic                       polarity_pin_i,
  input  wire logic                       auto_charge_pin_i,
  input  wire logic                       ganged_pin_i,
  // configuration and status from the hub core
  input  wire logic                       status_output_enable,
  input  wire logic                       ss_suspended,
  input  wire logic                       ss_connected,
  input  wire logic                       hub_connected,
  input  wire logic [`RSSP_NPORTS-1:0]    charge_enable_strap,
  input  wire logic [`RSSP_NPORTS-1:0]    port_power_on,
  // outputs
  output logic [`RSSP_NPORTS-1:0]         port_power_ctrl,
  output logic                            straps_valid,
  output logic                            smbus_slave_mode,
  output logic                            power_switching_en,
  output logic                            charge_mode_limit_bit,
  output logic [`RSSP_NPORTS-1:0]         auto_mode_en,
  output logic [1:0]                      divider_charge_profile,
  output logic [1:0]                      slave_addr_bits
);
  logic [1:0]   rst_sync_q;
  logic         rst_n;
  rssp_straps_t pin_s1_q, pin_s2_q, pin_s3_q;
  rssp_straps_t pin_live;
  rssp_straps_t straps_q, straps_d;
  rssp_state_t  state_q, state_d;
  logic [`RSSP_NPORTS-1:0] pwr_q, pwr_d;
  logic         bm_o_q, bm_o_d, pm_o_q, pm_o_d;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign pin_live = '{bus_mode_strap:            bus_mode_pin_i,
                      power_mgmt_strap_n:        power_mgmt_pin_i,
                      power_ctrl_polarity_strap: polarity_pin_i,
                      auto_charge_strap_n:       auto_charge_pin_i,
                      slave_addr_bit2_strap:     ganged_pin_i};

  // pins are asynchronous; three stages, stages two and three must agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else begin
      pin_s1_q <= pin_live;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // catch waits for the synchroniser to fill after release
  logic [1:0] fill_q, fill_d;
  always_comb begin
    state_d = state_q;
    straps_d = straps_q;
    fill_d = fill_q;
    case (state_q)
      RSSP_ST_RESET: begin
        if (fill_q != `RSSP_FILL_DONE) begin
          fill_d = fill_q + 2'h1;
        end else if (pin_s2_q == pin_s3_q) begin
          straps_d = pin_s3_q;
          state_d = RSSP_ST_RUN;
        end
      end
      RSSP_ST_RUN: begin
        state_d = RSSP_ST_RUN;
      end
      default: begin
        state_d = RSSP_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= RSSP_ST_RESET;
      straps_q <= '0;
      fill_q   <= 2'h0;
    end else begin
      state_q  <= state_d;
      straps_q <= straps_d;
      fill_q   <= fill_d;
    end
  end

  assign straps_valid          = (state_q == RSSP_ST_RUN);
  assign smbus_slave_mode      = straps_valid & ~straps_q.bus_mode_strap;
  assign power_switching_en    = straps_valid & ~straps_q.power_mgmt_strap_n;
  assign charge_mode_limit_bit = straps_q.power_mgmt_strap_n;
  assign slave_addr_bits = smbus_slave_mode ?
                           {straps_q.slave_addr_bit2_strap, straps_q.power_mgmt_strap_n} : 2'h0;

  // board must keep power management on for charge ports; no check here
  always_comb begin
    for (int i = 0; i < `RSSP_NPORTS; i++) begin
      auto_mode_en[i] = straps_valid & ~straps_q.auto_charge_strap_n
                        & charge_enable_strap[i] & ~hub_connected;
    end
    if (!straps_valid || straps_q.auto_charge_strap_n) begin
      divider_charge_profile = `RSSP_PROFILE_OFF;
    end else if (charge_mode_limit_bit) begin
      divider_charge_profile = `RSSP_PROFILE_MAX;
    end else begin
      divider_charge_profile = `RSSP_PROFILE_ALL;
    end
  end

  always_comb begin
    // off level follows polarity; once straps are caught, disabled switching holds ports at off; before that all outputs are 0
    for (int i = 0; i < `RSSP_NPORTS; i++) begin
      pwr_d[i] = (power_switching_en & port_power_on[i])
                 ~^ straps_q.power_ctrl_polarity_strap;
    end
    if (!straps_valid) begin
      pwr_d = '0;
    end
    bm_o_d = ss_suspended;
    pm_o_d = ss_connected;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q  <= '0;
      bm_o_q <= 1'b0;
      pm_o_q <= 1'b0;
    end else begin
      pwr_q  <= pwr_d;
      bm_o_q <= bm_o_d;
      pm_o_q <= pm_o_d;
    end
  end

  assign port_power_ctrl   = pwr_q;
  assign bus_mode_pin_o    = bm_o_q;
  assign power_mgmt_pin_o  = pm_o_q;
  // both status pins share one enable decode, so they can never disagree
  function automatic logic status_drive(input logic valid, input logic enable);
    return valid & enable;
  endfunction
  assign bus_mode_pin_oe   = status_drive(straps_valid, status_output_enable);
  assign power_mgmt_pin_oe = status_drive(straps_valid, status_output_enable);

  no_drive_early_a: assert property (@(posedge mclk)
    !straps_valid |-> !bus_mode_pin_oe && !power_mgmt_pin_oe)
    else $error("pin driven before straps caught");
  suspend_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    bus_mode_pin_oe |-> bus_mode_pin_o == $past(ss_suspended))
    else $error("suspend status wrong");
  connect_out_a: assert property (@(posedge mclk) disable iff (!rst_n)
    power_mgmt_pin_oe |-> power_mgmt_pin_o == $past(ss_connected))
    else $error("connect status wrong");
  mode_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
    straps_valid |-> smbus_slave_mode == !straps_q.bus_mode_strap)
    else $error("bus mode wrong");
  straps_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    straps_valid |=> $stable(straps_q) && straps_valid)
    else $error("straps changed after catch");
  limit_init_a: assert property (@(posedge mclk) disable iff (!rst_n)
    straps_valid |-> charge_mode_limit_bit == !power_switching_en)
    else $error("limit bit mismatch");
  profile_a: assert property (@(posedge mclk) disable iff (!rst_n)
    straps_valid && !straps_q.auto_charge_strap_n && charge_mode_limit_bit
    |-> divider_charge_profile == `RSSP_PROFILE_MAX)
    else $error("profile not limited");
  profile_all_a: assert property (@(posedge mclk) disable iff (!rst_n)
    straps_valid && !straps_q.auto_charge_strap_n && !charge_mode_limit_bit
    |-> divider_charge_profile == `RSSP_PROFILE_ALL)
    else $error("profile not all");
  addr_bit1_a: assert property (@(posedge mclk) disable iff (!rst_n)
    smbus_slave_mode |-> slave_addr_bits[0] == straps_q.power_mgmt_strap_n)
    else $error("address bit 1 wrong");
  power_pol_a: assert property (@(posedge mclk) disable iff (!rst_n)
    straps_valid && $past(straps_valid) && !$past(power_switching_en)
    |-> port_power_ctrl == {`RSSP_NPORTS{~straps_q.power_ctrl_polarity_strap}})
    else $error("power output not off");

  // capture waits out the synchroniser fill, then needs agreeing stages
  sequence sync_fill_s;
    !straps_valid [*4];
  endsequence
  sequence caught_s;
    ##[0:7] straps_valid;
  endsequence
  release_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> sync_fill_s ##1 caught_s)
    else $error("strap capture timing wrong");
  strap_catch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(straps_valid) |-> straps_q == $past(pin_s3_q))
    else $error("straps not taken from synchroniser");
  addr_bit2_a: assert property (@(posedge mclk) disable iff (!rst_n)
    smbus_slave_mode |-> slave_addr_bits[1] == straps_q.slave_addr_bit2_strap)
    else $error("address bit 2 wrong");
  auto_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    straps_valid |-> auto_mode_en == (straps_q.auto_charge_strap_n ? '0 :
                     (charge_enable_strap & ~{`RSSP_NPORTS{hub_connected}})))
    else $error("auto mode enables wrong");
  power_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
    straps_valid && $past(straps_valid) && $past(power_switching_en)
    |-> port_power_ctrl ==
        ($past(port_power_on) ~^ {`RSSP_NPORTS{straps_q.power_ctrl_polarity_strap}}))
    else $error("power output not following request");
endmodule

// ---- verif/rssp_board.sv ----
module rssp_board
  import rssp_pkg::*;
(
  // strap resistors and charge-enable straps
  input  wire rssp_straps_t straps,
  input  wire logic [3:0]   ces,
  // dual-purpose pads
  input  wire logic         bm_o,
  input  wire logic         bm_oe,
  input  wire logic         pm_o,
  input  wire logic         pm_oe,
  output logic              bm_pin,
  output logic              pm_pin,
  output logic              pol_pin,
  output logic              ac_pin,
  output logic              ga_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  assign bm_pin  = bm_oe ? bm_o : straps.bus_mode_strap;
  // any charging port forces full power management on
  assign pm_pin  = pm_oe ? pm_o : (straps.power_mgmt_strap_n & ~|ces);
  assign pol_pin = straps.power_ctrl_polarity_strap;
  assign ac_pin  = straps.auto_charge_strap_n;
  assign ga_pin  = straps.slave_addr_bit2_strap;
endmodule

// ---- verif/tb_top.sv ----
`include "rssp_consts.svh"
module tb_top;
  import rssp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rstn, soe, ssus, scon, hubc, bmi, bmo, bmoe, pmi, pmo, pmoe, poli, aci, gai;
  logic sv, smb, pse, cml, pmn;
  logic [3:0] ces, ppon, ppc, ame;
  logic [1:0] prof, sab;
  rssp_straps_t st, cap;
  int fails, n_compared, seed, k, t;
  rssp_board board (.straps(st), .ces(ces), .bm_o(bmo), .bm_oe(bmoe), .pm_o(pmo),
    .pm_oe(pmoe), .bm_pin(bmi), .pm_pin(pmi), .pol_pin(poli), .ac_pin(aci), .ga_pin(gai));
  rssp_top dut (.mclk(mclk), .rstn(rstn), .bus_mode_pin_i(bmi), .bus_mode_pin_o(bmo),
    .bus_mode_pin_oe(bmoe), .power_mgmt_pin_i(pmi), .power_mgmt_pin_o(pmo),
    .power_mgmt_pin_oe(pmoe), .polarity_pin_i(poli), .auto_charge_pin_i(aci),
    .ganged_pin_i(gai), .status_output_enable(soe), .ss_suspended(ssus),
    .ss_connected(scon), .hub_connected(hubc), .charge_enable_strap(ces),
    .port_power_on(ppon), .port_power_ctrl(ppc), .straps_valid(sv), .smbus_slave_mode(smb),
    .power_switching_en(pse), .charge_mode_limit_bit(cml), .auto_mode_en(ame),
    .divider_charge_profile(prof), .slave_addr_bits(sab));
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  function automatic logic [1:0] exp_prof(input rssp_straps_t s, input logic limit);
    return s.auto_charge_strap_n ? `RSSP_PROFILE_OFF :
           (limit ? `RSSP_PROFILE_MAX : `RSSP_PROFILE_ALL);
  endfunction
  function automatic logic [1:0] exp_addr(input rssp_straps_t s, input logic pm);
    return s.bus_mode_strap ? 2'h0 : {s.slave_addr_bit2_strap, pm};
  endfunction
  function automatic logic [3:0] exp_auto(input rssp_straps_t s, input logic [3:0] ce,
                                          input logic hc);
    return s.auto_charge_strap_n ? 4'h0 : (ce & {4{~hc}});
  endfunction
  function automatic logic [3:0] exp_pwr(input logic [3:0] on, input logic en,
                                         input rssp_straps_t s);
    return (on & {4{en}}) ^ {4{~s.power_ctrl_polarity_strap}};
  endfunction
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    finish_test;
  end
  initial begin
    seed = 17;
    {rstn, soe, ssus, scon, hubc, ppon, ces, st} = '0;
    for (t = 0; t < 12; t++) begin
      @(negedge mclk) rstn = 0;
      // corner cases in tests 1 and 2: all five pin straps high, then all low; charge-enable straps stay random
      st = (t == 1) ? 5'h1f : (t == 2) ? 5'h00 : 5'($random(seed));
      ces = (t == 0) ? 4'h0 : 4'($random(seed));
      soe = 1;
      repeat (10) @(negedge mclk);
      chk({bmoe, pmoe, sv}, 4'h0, "pins driven in reset");
      rstn = 1;
      for (k = 0; k < 20 && sv !== 1'b1; k++) @(negedge mclk);
      chk({3'h0, sv}, 4'h1, "straps not caught");
      cap = st;
      pmn = st.power_mgmt_strap_n & ~|ces;
      chk({3'h0, smb}, {3'h0, ~cap.bus_mode_strap}, "bus mode");
      chk({pse, cml}, {~pmn, pmn}, "power strap");
      chk(sab, exp_addr(cap, pmn), "address");
      chk(ame, exp_auto(cap, ces, hubc), "auto mode");
      chk(prof, exp_prof(cap, pmn), "profile");
      st = ~st;
      repeat (8) begin
        @(negedge mclk) {soe, ssus, scon, hubc, ppon} = 8'($random(seed));
        @(negedge mclk);
        chk({bmoe, pmoe}, {soe, soe}, "output enable");
        chk({bmo, pmo}, {ssus, scon}, "status pins");
        chk(ppc, exp_pwr(ppon, pse, cap), "power ctrl");
        chk(ame, exp_auto(cap, ces, hubc), "auto mode");
      end
      chk({smb, cml}, {~cap.bus_mode_strap, pmn}, "late strap taken");
      $display("test %0d done", t);
    end
    finish_test;
  end
endmodule
